// ### rpsc_pkg.sv
// Shared constants and types for the receive payload and signaling control block
package rpsc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PAY_CFG = 8'hd0;
  localparam logic [7:0] ADDR_PAY_EN = 8'hd1;
  localparam logic [7:0] ADDR_SIG_CFG = 8'hd2;
  localparam logic [7:0] ADDR_IND_STAT = 8'hd3;
  localparam logic [7:0] ADDR_IND_CTRL = 8'hd4;
  localparam logic [7:0] ADDR_IND_DATA = 8'hd5;
  localparam logic [7:0] ADDR_COS0 = 8'hd6;
  localparam logic [7:0] ADDR_COS1 = 8'hd7;
  localparam logic [7:0] ADDR_COS2 = 8'hd8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_PAYLOAD_CONTROL_ENABLE = 0;
  localparam int BIT_POL = 1;
  localparam int BIT_SIGNALING_FIX_ENABLE = 2;
  localparam int BIT_TWO_BIT_SIGNALING_POSITION = 3;
  localparam int BIT_SIXTEEN_STATE_SELECT = 0;
  localparam int BIT_SIGNALING_INTERRUPT_ENABLE = 1;
  localparam int BIT_DEB = 2;
  localparam int BIT_FREEZE = 3;
  localparam int BIT_BUSY = 0;
  localparam int BIT_RWN = 7;
  localparam int BIT_EXTRACT = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PAY_CFG = 8'h00;
  localparam logic [7:0] RST_PAY_EN = 8'h00;
  localparam logic [7:0] RST_SIG_CFG = 8'h01;
  localparam logic [7:0] RST_IND_CTRL = 8'h00;
  localparam logic [7:0] RST_IND_DATA = 8'h00;

  // ----------------------------------------------------------------
  // Indirect space and timing
  // ----------------------------------------------------------------
  localparam int NUM_CHAN = 24;
  localparam logic [6:0] IND_ADDR_FIRST = 7'h01;
  localparam logic [6:0] IND_ADDR_LAST = 7'h18;
  localparam logic [4:0] LAST_CHAN = 5'h17;
  localparam logic [1:0] BUSY_CYCLES = 2'h2;

  // ----------------------------------------------------------------
  // Substitution codes and milliwatt patterns
  // ----------------------------------------------------------------
  localparam logic [2:0] CHANNEL_SUBSTITUTION_SELECT_NONE = 3'h0;
  localparam logic [2:0] CHANNEL_SUBSTITUTION_SELECT_TRUNK = 3'h1;
  localparam logic [2:0] CHANNEL_SUBSTITUTION_SELECT_ALAW = 3'h2;
  localparam logic [2:0] CHANNEL_SUBSTITUTION_SELECT_MULAW = 3'h3;
  localparam logic [63:0] ALAW_MW = 64'h34212134b4a1a1b4;
  localparam logic [63:0] MULAW_MW = 64'h1e0b0b1e9e8b8b9e;

  typedef enum logic [1:0] {
    FMT_SF = 2'h0,
    FMT_ESF = 2'h1,
    FMT_SLC = 2'h2,
    FMT_DM = 2'h3
  } rpsc_fmt_type;

endpackage : rpsc_pkg

// ### rpsc_if.sv
// Register port joining the host end and the device end
`timescale 1ns/1ns
`default_nettype none

interface rpsc_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;

  modport dev (
    input wr,
    input rd,
    input addr,
    input wdata,
    output rdata,
    output rvalid
  );

  modport host (
    output wr,
    output rd,
    output addr,
    output wdata,
    input rdata,
    input rvalid
  );
endinterface : rpsc_if

`default_nettype wire

// ### rpsc_dev.sv
// Device end: payload replacement, signaling capture and indirect signaling buffer
`timescale 1ns/1ns
`default_nettype none

module rpsc_dev (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  rpsc_if.dev bus,
  // Line status
  input wire rpsc_pkg::rpsc_fmt_type i_fmt,
  input wire logic i_frame_sync,
  // Received payload
  input wire logic i_pay_valid,
  input wire logic [4:0] i_pay_chan,
  input wire logic [7:0] i_pay_data,
  input wire logic [2:0] i_pay_channel_substitution_select,
  input wire logic [7:0] i_pay_trunk,
  // Received signaling codewords
  input wire logic i_sig_valid,
  input wire logic [4:0] i_sig_chan,
  input wire logic [3:0] i_sig_abcd,
  // Processed payload
  output logic o_pay_valid,
  output logic [7:0] o_pay_data,
  output logic [3:0] o_pay_sig,
  // Interrupt
  output logic o_sig_irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [23:0] chan_onehot(input logic [4:0] ch);
    chan_onehot = 24'h000001 << ch;
  endfunction : chan_onehot

  function automatic logic [7:0] mw_byte(input logic [63:0] pat, input logic [2:0] ph);
    mw_byte = pat[63 - 8 * ph -: 8];
  endfunction : mw_byte

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] pay_cfg_reg;
  logic [7:0] pay_en_reg;
  logic [7:0] sig_cfg_reg;
  logic [7:0] ind_ctrl_reg;
  logic [7:0] ind_data_reg;
  logic [23:0] cos_reg;
  logic busy_reg;
  logic [1:0] busy_cnt_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic extract_reg [rpsc_pkg::NUM_CHAN];
  logic [3:0] abcd_reg [rpsc_pkg::NUM_CHAN];
  logic [3:0] prev_reg [rpsc_pkg::NUM_CHAN];
  logic [2:0] mw_phase_reg;
  logic pay_valid_reg;
  logic [7:0] pay_data_reg;
  logic [3:0] pay_sig_reg;

  logic wr_ctrl;
  logic [6:0] ind_addr;
  logic ind_in_range;
  logic [4:0] ind_chan;
  logic [23:0] cos_clr;
  logic [23:0] cos_set;
  logic sig_fmt_ok;
  logic [3:0] code_in;
  logic sig_accept;
  logic [2:0] channel_substitution_select_sel;
  logic [3:0] sig_fixed;

  assign wr_ctrl = bus.wr && (bus.addr == rpsc_pkg::ADDR_IND_CTRL) && !busy_reg;
  assign ind_addr = ind_ctrl_reg[6:0];
  assign ind_in_range = (ind_addr >= rpsc_pkg::IND_ADDR_FIRST) &&
                        (ind_addr <= rpsc_pkg::IND_ADDR_LAST);
  assign ind_chan = 5'(ind_addr - rpsc_pkg::IND_ADDR_FIRST);

  // ----------------------------------------------------------------
  // Direct register writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pay_cfg_reg <= rpsc_pkg::RST_PAY_CFG;
      pay_en_reg <= rpsc_pkg::RST_PAY_EN;
      sig_cfg_reg <= rpsc_pkg::RST_SIG_CFG;
      ind_ctrl_reg <= rpsc_pkg::RST_IND_CTRL;
    end else if (bus.wr) begin
      if (bus.addr == rpsc_pkg::ADDR_PAY_CFG) begin
        pay_cfg_reg <= {5'h00, bus.wdata[2:0]};
      end
      if (bus.addr == rpsc_pkg::ADDR_PAY_EN) begin
        pay_en_reg <= {4'h0, bus.wdata[3:0]};
      end
      if (bus.addr == rpsc_pkg::ADDR_SIG_CFG) begin
        sig_cfg_reg <= {4'h0, bus.wdata[3:0]};
      end
      if (wr_ctrl) begin
        ind_ctrl_reg <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indirect access engine
  // ----------------------------------------------------------------
  // Busy runs a fixed count so that software sees a deterministic wait
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_reg <= 1'b0;
      busy_cnt_reg <= 2'h0;
    end else if (wr_ctrl) begin
      busy_reg <= 1'b1;
      busy_cnt_reg <= rpsc_pkg::BUSY_CYCLES;
    end else if (busy_reg) begin
      busy_cnt_reg <= busy_cnt_reg - 2'h1;
      if (busy_cnt_reg == 2'h1) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Data written while busy is ignored so an access in flight keeps its byte
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ind_data_reg <= rpsc_pkg::RST_IND_DATA;
    end else if (busy_reg && busy_cnt_reg == 2'h1 && ind_ctrl_reg[rpsc_pkg::BIT_RWN]) begin
      if (ind_in_range) begin
        ind_data_reg <= {3'h0, extract_reg[ind_chan], abcd_reg[ind_chan]};
      end else begin
        ind_data_reg <= 8'h00;
      end
    end else if (bus.wr && bus.addr == rpsc_pkg::ADDR_IND_DATA && !busy_reg) begin
      ind_data_reg <= bus.wdata;
    end
  end

  for (genvar c = 0; c < rpsc_pkg::NUM_CHAN; c++) begin : g_extract
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        extract_reg[c] <= 1'b0;
      end else if (busy_reg && busy_cnt_reg == 2'h1 && !ind_ctrl_reg[rpsc_pkg::BIT_RWN] &&
                   ind_in_range && ind_chan == 5'(c)) begin
        extract_reg[c] <= ind_data_reg[rpsc_pkg::BIT_EXTRACT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Signaling capture
  // ----------------------------------------------------------------
  assign sig_fmt_ok = (i_fmt != rpsc_pkg::FMT_DM);

  always_comb begin
    if (i_fmt == rpsc_pkg::FMT_SF) begin
      code_in = {i_sig_abcd[3:2], i_sig_abcd[3:2]};
    end else if (sig_cfg_reg[rpsc_pkg::BIT_SIXTEEN_STATE_SELECT]) begin
      code_in = i_sig_abcd;
    end else begin
      code_in = {i_sig_abcd[3:2], 2'b00};
    end
  end

  assign sig_accept = i_sig_valid && (i_sig_chan <= rpsc_pkg::LAST_CHAN) && sig_fmt_ok &&
                      i_frame_sync && extract_reg[i_sig_chan] &&
                      !sig_cfg_reg[rpsc_pkg::BIT_FREEZE] &&
                      (!sig_cfg_reg[rpsc_pkg::BIT_DEB] || code_in == prev_reg[i_sig_chan]);

  assign cos_set = (sig_accept && code_in != abcd_reg[i_sig_chan]) ?
                   chan_onehot(i_sig_chan) : 24'h000000;

  for (genvar c = 0; c < rpsc_pkg::NUM_CHAN; c++) begin : g_sig
    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        abcd_reg[c] <= 4'h0;
        prev_reg[c] <= 4'h0;
      end else if (i_sig_valid && i_sig_chan == 5'(c)) begin
        prev_reg[c] <= code_in;
        if (sig_accept) begin
          abcd_reg[c] <= code_in;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Change flags and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    cos_clr = 24'h000000;
    if (bus.wr && bus.addr == rpsc_pkg::ADDR_COS0) begin
      cos_clr[7:0] = bus.wdata;
    end
    if (bus.wr && bus.addr == rpsc_pkg::ADDR_COS1) begin
      cos_clr[15:8] = bus.wdata;
    end
    if (bus.wr && bus.addr == rpsc_pkg::ADDR_COS2) begin
      cos_clr[23:16] = bus.wdata;
    end
  end

  // A change arriving with its own clear is kept
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cos_reg <= 24'h000000;
    end else begin
      cos_reg <= (cos_reg & ~cos_clr) | cos_set;
    end
  end

  assign o_sig_irq = sig_cfg_reg[rpsc_pkg::BIT_SIGNALING_INTERRUPT_ENABLE] && (cos_reg != 24'h000000);

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= bus.rd;
      if (bus.rd) begin
        unique case (bus.addr)
          rpsc_pkg::ADDR_PAY_CFG: rdata_reg <= pay_cfg_reg;
          rpsc_pkg::ADDR_PAY_EN: rdata_reg <= pay_en_reg;
          rpsc_pkg::ADDR_SIG_CFG: rdata_reg <= sig_cfg_reg;
          rpsc_pkg::ADDR_IND_STAT: rdata_reg <= {7'h00, busy_reg};
          rpsc_pkg::ADDR_IND_CTRL: rdata_reg <= ind_ctrl_reg;
          rpsc_pkg::ADDR_IND_DATA: rdata_reg <= ind_data_reg;
          rpsc_pkg::ADDR_COS0: rdata_reg <= cos_reg[7:0];
          rpsc_pkg::ADDR_COS1: rdata_reg <= cos_reg[15:8];
          rpsc_pkg::ADDR_COS2: rdata_reg <= cos_reg[23:16];
          default: rdata_reg <= 8'h00;
        endcase
      end
    end
  end

  assign bus.rdata = rdata_reg;
  assign bus.rvalid = rvalid_reg;

  // ----------------------------------------------------------------
  // Payload replacement
  // ----------------------------------------------------------------
  assign channel_substitution_select_sel = (pay_cfg_reg[2:0] == rpsc_pkg::CHANNEL_SUBSTITUTION_SELECT_NONE) ?
                     i_pay_channel_substitution_select : pay_cfg_reg[2:0];

  always_comb begin
    sig_fixed = abcd_reg[(i_pay_chan <= rpsc_pkg::LAST_CHAN) ? i_pay_chan : 5'h00];
    if (pay_en_reg[rpsc_pkg::BIT_SIGNALING_FIX_ENABLE] && sig_fmt_ok) begin
      sig_fixed = {4{pay_en_reg[rpsc_pkg::BIT_POL]}};
    end
    if (pay_en_reg[rpsc_pkg::BIT_TWO_BIT_SIGNALING_POSITION] &&
        (i_fmt == rpsc_pkg::FMT_ESF || i_fmt == rpsc_pkg::FMT_SLC)) begin
      sig_fixed = {sig_fixed[3:2], 2'b00};
    end
  end

  // Milliwatt phase steps once per frame, after the last channel
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mw_phase_reg <= 3'h0;
    end else if (i_pay_valid && i_pay_chan == rpsc_pkg::LAST_CHAN) begin
      mw_phase_reg <= mw_phase_reg + 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pay_valid_reg <= 1'b0;
      pay_data_reg <= 8'h00;
      pay_sig_reg <= 4'h0;
    end else begin
      pay_valid_reg <= i_pay_valid;
      pay_data_reg <= i_pay_data;
      pay_sig_reg <= abcd_reg[(i_pay_chan <= rpsc_pkg::LAST_CHAN) ? i_pay_chan : 5'h00];
      if (pay_en_reg[rpsc_pkg::BIT_PAYLOAD_CONTROL_ENABLE]) begin
        pay_sig_reg <= sig_fixed;
        unique case (channel_substitution_select_sel)
          rpsc_pkg::CHANNEL_SUBSTITUTION_SELECT_TRUNK: pay_data_reg <= i_pay_trunk;
          rpsc_pkg::CHANNEL_SUBSTITUTION_SELECT_ALAW: pay_data_reg <= mw_byte(rpsc_pkg::ALAW_MW, mw_phase_reg);
          rpsc_pkg::CHANNEL_SUBSTITUTION_SELECT_MULAW: pay_data_reg <= mw_byte(rpsc_pkg::MULAW_MW, mw_phase_reg);
          default: pay_data_reg <= i_pay_data;
        endcase
      end
    end
  end

  assign o_pay_valid = pay_valid_reg;
  assign o_pay_data = pay_data_reg;
  assign o_pay_sig = pay_sig_reg;

endmodule : rpsc_dev

`default_nettype wire

// ### rpsc_host.sv
// Host end: direct register access and the indirect access sequence
`timescale 1ns/1ns
`default_nettype none

module rpsc_host (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Command port
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic i_cmd_indirect,
  input wire logic [7:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_wdata,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  // Register port
  rpsc_if.host bus
);

  typedef enum logic [9:0] {
    S_IDLE = 10'h001,
    S_DATA = 10'h002,
    S_CTRL = 10'h004,
    S_POLL = 10'h008,
    S_PWAIT = 10'h010,
    S_RDATA = 10'h020,
    S_RWAIT = 10'h040,
    S_DIR = 10'h080,
    S_DWAIT = 10'h100,
    S_DONE = 10'h200
  } rpsc_hst_type;

  rpsc_hst_type state_reg;
  rpsc_hst_type state_next;
  logic write_reg;
  logic indirect_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rsp_data_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (i_cmd_valid) begin
          if (!i_cmd_indirect) begin
            state_next = S_DIR;
          end else if (i_cmd_write) begin
            state_next = S_DATA;
          end else begin
            state_next = S_CTRL;
          end
        end
      end
      S_DATA: state_next = S_CTRL;
      S_CTRL: state_next = S_POLL;
      S_POLL: state_next = S_PWAIT;
      S_PWAIT: begin
        if (bus.rvalid) begin
          if (bus.rdata[rpsc_pkg::BIT_BUSY]) begin
            state_next = S_POLL;
          end else if (write_reg) begin
            state_next = S_DONE;
          end else begin
            state_next = S_RDATA;
          end
        end
      end
      S_RDATA: state_next = S_RWAIT;
      S_RWAIT: begin
        if (bus.rvalid) begin
          state_next = S_DONE;
        end
      end
      S_DIR: state_next = write_reg ? S_DONE : S_DWAIT;
      S_DWAIT: begin
        if (bus.rvalid) begin
          state_next = S_DONE;
        end
      end
      S_DONE: state_next = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Command capture and response
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      write_reg <= 1'b0;
      indirect_reg <= 1'b0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
    end else if (state_reg == S_IDLE && i_cmd_valid) begin
      write_reg <= i_cmd_write;
      indirect_reg <= i_cmd_indirect;
      addr_reg <= i_cmd_addr;
      wdata_reg <= i_cmd_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rsp_data_reg <= 8'h00;
    end else if (bus.rvalid && (state_reg == S_RWAIT || state_reg == S_DWAIT)) begin
      rsp_data_reg <= bus.rdata;
    end
  end

  assign o_cmd_ready = (state_reg == S_IDLE);
  assign o_rsp_valid = (state_reg == S_DONE);
  assign o_rsp_data = rsp_data_reg;

  // ----------------------------------------------------------------
  // Bus drive
  // ----------------------------------------------------------------
  // Strobes decode from state; address and data mux only held flops and fixed register offsets
  assign bus.wr = (state_reg == S_DATA) || (state_reg == S_CTRL) ||
                  (state_reg == S_DIR && write_reg);
  assign bus.rd = (state_reg == S_POLL) || (state_reg == S_RDATA) ||
                  (state_reg == S_DIR && !write_reg);

  always_comb begin
    bus.addr = addr_reg;
    bus.wdata = wdata_reg;
    unique case (state_reg)
      S_DATA: bus.addr = rpsc_pkg::ADDR_IND_DATA;
      S_CTRL: begin
        bus.addr = rpsc_pkg::ADDR_IND_CTRL;
        bus.wdata = {!write_reg, addr_reg[6:0]};
      end
      S_POLL: bus.addr = rpsc_pkg::ADDR_IND_STAT;
      S_RDATA: bus.addr = rpsc_pkg::ADDR_IND_DATA;
      default: bus.addr = addr_reg;
    endcase
  end

endmodule : rpsc_host

`default_nettype wire

// ### rpsc_checker.sv
// Checker on the register port between the host end and the device end
`timescale 1ns/1ns
`default_nettype none

module rpsc_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // ----
  // Helpers
  // ----
  logic data_wr_reg;
  wire logic ctl_wr = wr && addr == rpsc_pkg::ADDR_IND_CTRL;

  always_ff @(posedge i_clk) begin
    data_wr_reg <= !i_rst && wr && addr == rpsc_pkg::ADDR_IND_DATA;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // ----
  // Properties
  // ----
  property p_rd_answer;
    rd |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered next cycle");

  property p_rvalid_cause;
    rvalid |-> $past(rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("answer without read");

  property p_data_first;
    (ctl_wr && !wdata[rpsc_pkg::BIT_RWN]) |-> data_wr_reg;
  endproperty
  a_data_first: assert property (p_data_first)
    else $error("indirect write without data load");

  property p_busy_seen;
    ctl_wr |=> (rd && addr == rpsc_pkg::ADDR_IND_STAT) ##1 (rvalid && rdata[0]);
  endproperty
  a_busy_seen: assert property (p_busy_seen)
    else $error("busy not shown after access start");

  property p_busy_ends;
    ctl_wr |-> ##4 (rvalid && !rdata[0]);
  endproperty
  a_busy_ends: assert property (p_busy_ends)
    else $error("busy not cleared in time");

  property p_addr_range;
    ctl_wr |-> wdata[6:0] >= rpsc_pkg::IND_ADDR_FIRST && wdata[6:0] <= rpsc_pkg::IND_ADDR_LAST;
  endproperty
  a_addr_range: assert property (p_addr_range)
    else $error("indirect address out of range");

  property p_read_fetch;
    (ctl_wr && wdata[7]) |-> ##5 (rd && addr == rpsc_pkg::ADDR_IND_DATA) ##1 rvalid;
  endproperty
  a_read_fetch: assert property (p_read_fetch)
    else $error("indirect read data not fetched");

  property p_unmapped_zero;
    (rd && addr > rpsc_pkg::ADDR_COS2) |=> rvalid && rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");
endmodule : rpsc_checker

`default_nettype wire

// ### rpsc_bench.sv
// Self-checking bench for the host and device ends joined by the register port
`timescale 1ns/1ns
`default_nettype none

module rpsc_bench;
  logic i_clk, i_rst, cmd_valid, cmd_write, cmd_ind, cmd_ready, rsp_valid;
  logic [7:0] cmd_addr, cmd_wdata, rsp_data, pay_data, pay_trunk, out_data, q;
  logic frame_sync, pay_valid, sig_valid, out_valid, sig_irq;
  logic [4:0] pay_chan, sig_chan;
  logic [2:0] pay_channel_substitution_select;
  logic [3:0] sig_abcd, out_sig;
  rpsc_pkg::rpsc_fmt_type fmt;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  rpsc_if i_rpsc_if ();
  rpsc_host i_rpsc_host (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_indirect(cmd_ind), .i_cmd_addr(cmd_addr),
    .i_cmd_wdata(cmd_wdata), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
    .o_rsp_data(rsp_data), .bus(i_rpsc_if));
  rpsc_dev i_rpsc_dev (.i_clk(i_clk), .i_rst(i_rst), .bus(i_rpsc_if), .i_fmt(fmt),
    .i_frame_sync(frame_sync), .i_pay_valid(pay_valid), .i_pay_chan(pay_chan),
    .i_pay_data(pay_data), .i_pay_channel_substitution_select(pay_channel_substitution_select), .i_pay_trunk(pay_trunk),
    .i_sig_valid(sig_valid), .i_sig_chan(sig_chan), .i_sig_abcd(sig_abcd),
    .o_pay_valid(out_valid), .o_pay_data(out_data), .o_pay_sig(out_sig), .o_sig_irq(sig_irq));
  rpsc_checker i_rpsc_checker (.i_clk(i_clk), .i_rst(i_rst), .wr(i_rpsc_if.wr),
    .rd(i_rpsc_if.rd), .addr(i_rpsc_if.addr), .wdata(i_rpsc_if.wdata),
    .rdata(i_rpsc_if.rdata), .rvalid(i_rpsc_if.rvalid));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // Whole run needs about 340 cycles
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      summarize();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // One command at a time; the next is offered only after the response
  task automatic cmd(input logic w, input logic ind, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge i_clk);
    #1;
    check({7'h00, cmd_ready}, 8'h01);
    {cmd_valid, cmd_write, cmd_ind, cmd_addr, cmd_wdata} = {1'b1, w, ind, a, d};
    @(posedge i_clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 12) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    if (n == 12) check(8'h01, 8'h00);
    q = rsp_data;
  endtask : cmd

  task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
    cmd(1'b1, ind, a, d);
  endtask : wr

  task automatic rd(input logic ind, input logic [7:0] a, input logic [7:0] e);
    cmd(1'b0, ind, a, 8'h00);
    check(q, e);
  endtask : rd

  task automatic sig(input logic [4:0] c, input logic [3:0] v);
    @(posedge i_clk);
    #1;
    {sig_valid, sig_chan, sig_abcd} = {1'b1, c, v};
    @(posedge i_clk);
    #1;
    sig_valid = 1'b0;
  endtask : sig

  task automatic pay(input logic [4:0] c, input logic [7:0] d, input logic [7:0] e,
                     input logic [3:0] es);
    @(posedge i_clk);
    #1;
    {pay_valid, pay_chan, pay_data} = {1'b1, c, d};
    @(posedge i_clk);
    #1;
    pay_valid = 1'b0;
    check(out_data, e);
    check({3'h0, out_valid, out_sig}, {4'h1, es});
  endtask : pay

  // ----
  // Sequence
  // ----
  initial begin
    {cmd_valid, cmd_write, cmd_ind, cmd_addr, cmd_wdata} = '0;
    {pay_valid, pay_chan, pay_data, pay_channel_substitution_select, pay_trunk} = '0;
    {sig_valid, sig_chan, sig_abcd} = '0;
    fmt = rpsc_pkg::FMT_ESF;
    frame_sync = 1'b1;
    i_rst = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    for (int k = 0; k < 10; k++) rd(1'b0, 8'(8'hd0 + k), (k == 2) ? 8'h01 : 8'h00);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'hff);
    rd(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h0f);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h00);
    wr(1'b1, 8'h01, 8'h10);
    rd(1'b1, 8'h01, 8'h10);
    wr(1'b1, 8'h18, 8'h10);
    rd(1'b1, 8'h18, 8'h10);
    sig(5'h00, 4'ha);
    rd(1'b1, 8'h01, 8'h1a);
    rd(1'b0, rpsc_pkg::ADDR_COS0, 8'h01);
    check({7'h00, sig_irq}, 8'h00);
    wr(1'b0, rpsc_pkg::ADDR_SIG_CFG, 8'h03);
    check({7'h00, sig_irq}, 8'h01);
    wr(1'b0, rpsc_pkg::ADDR_COS0, 8'h00);
    rd(1'b0, rpsc_pkg::ADDR_COS0, 8'h01);
    wr(1'b0, rpsc_pkg::ADDR_COS0, 8'h01);
    rd(1'b0, rpsc_pkg::ADDR_COS0, 8'h00);
    check({7'h00, sig_irq}, 8'h00);
    sig(5'h17, 4'h5);
    rd(1'b0, rpsc_pkg::ADDR_COS2, 8'h80);
    sig(5'h00, 4'ha);
    rd(1'b0, rpsc_pkg::ADDR_COS0, 8'h00);
    wr(1'b0, rpsc_pkg::ADDR_SIG_CFG, 8'h00);
    sig(5'h00, 4'hf);
    rd(1'b1, 8'h01, 8'h1c);
    wr(1'b0, rpsc_pkg::ADDR_SIG_CFG, 8'h08);
    sig(5'h00, 4'h3);
    rd(1'b1, 8'h01, 8'h1c);
    wr(1'b0, rpsc_pkg::ADDR_SIG_CFG, 8'h05);
    sig(5'h00, 4'h6);
    rd(1'b1, 8'h01, 8'h1c);
    sig(5'h00, 4'h6);
    rd(1'b1, 8'h01, 8'h16);
    fmt = rpsc_pkg::FMT_SF;
    wr(1'b0, rpsc_pkg::ADDR_SIG_CFG, 8'h00);
    sig(5'h00, 4'h4);
    rd(1'b1, 8'h01, 8'h15);
    // Out of sync or extraction off: stored bits must not move
    frame_sync = 1'b0;
    sig(5'h00, 4'h8);
    rd(1'b1, 8'h01, 8'h15);
    frame_sync = 1'b1;
    sig(5'h01, 4'h8);
    rd(1'b1, 8'h02, 8'h00);
    fmt = rpsc_pkg::FMT_ESF;
    {pay_channel_substitution_select, pay_trunk} = {3'h1, 8'h3c};
    pay(5'h00, 8'h55, 8'h55, 4'h5);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h01);
    pay(5'h00, 8'h55, 8'h3c, 4'h5);
    pay_channel_substitution_select = 3'h0;
    pay(5'h00, 8'h55, 8'h55, 4'h5);
    wr(1'b0, rpsc_pkg::ADDR_PAY_CFG, 8'h01);
    pay(5'h00, 8'h55, 8'h3c, 4'h5);
    for (int m = 2; m < 4; m++) begin
      wr(1'b0, rpsc_pkg::ADDR_PAY_CFG, 8'(m));
      for (int k = 0; k < 8; k++) begin
        pay(5'h17, 8'h55, 8'((m == 2 ? rpsc_pkg::ALAW_MW : rpsc_pkg::MULAW_MW) >> (56 - 8 * k)),
            4'h5);
      end
    end
    wr(1'b0, rpsc_pkg::ADDR_PAY_CFG, 8'h05);
    pay(5'h00, 8'h55, 8'h55, 4'h5);
    wr(1'b0, rpsc_pkg::ADDR_PAY_CFG, 8'h00);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h05);
    pay(5'h00, 8'h55, 8'h55, 4'h0);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h07);
    pay(5'h00, 8'h55, 8'h55, 4'hf);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h03);
    pay(5'h00, 8'h55, 8'h55, 4'h5);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h09);
    pay(5'h00, 8'h55, 8'h55, 4'h4);
    fmt = rpsc_pkg::FMT_SLC;
    pay(5'h00, 8'h55, 8'h55, 4'h4);
    fmt = rpsc_pkg::FMT_SF;
    pay(5'h00, 8'h55, 8'h55, 4'h5);
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h06);
    pay(5'h00, 8'h55, 8'h55, 4'h5);
    fmt = rpsc_pkg::FMT_DM;
    wr(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h05);
    pay(5'h00, 8'h55, 8'h55, 4'h5);
    // Second reset in mid-run must bring back the reset values
    i_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    rd(1'b0, rpsc_pkg::ADDR_PAY_EN, 8'h00);
    rd(1'b0, rpsc_pkg::ADDR_SIG_CFG, 8'h01);
    rd(1'b0, rpsc_pkg::ADDR_COS0, 8'h00);
    rd(1'b1, 8'h01, 8'h00);
    summarize();
  end
endmodule : rpsc_bench

`default_nettype wire
